// >>> src/pwm_pkg.sv
// ============================================================
// Contract
// - Time base is timer count plus phase bits.
// - Mode field selects single, half or full bridge.
// - Single mode drives only steered outputs.
// - Half-bridge variants lack outputs C and D.
// - Dead band is four clocks per count.
// - Half bridge: A is PWM, B its complement.
// - Half bridge delays each output before activation.
// - Dead band beyond duty keeps output inactive.
// - Forward: A active, D modulated, B C off.
// - Reverse: C active, B modulated, A D off.
// - Direction change applies from next PWM period.
// - Pending change swaps A/C four timer cycles early.
// - Full bridge modes insert no dead band.
// - Three-bit field selects the shutdown sources.
// - Status bit reads one while shut down.
// - Shutdown status stays set until cleared.
// - Shutdown forces pins per pair state selector.
// - Shutdown is level sensitive and persists.
// - Status writes ignored while condition persists.
// - Restart resumes only at next period start.
// - Auto-restart clears status when condition ends.
// - First enable waits for a new period.
// - Dead band only on inactive-to-active edges.
package pwm_pkg;

	// ============================================================
	// Output mode field codes.
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_HALF = 2'h2;
	localparam logic [1:0] MODE_FULL_FWD = 2'h1;
	localparam logic [1:0] MODE_FULL_REV = 2'h3;
	localparam int MODE_FULL_BIT = 0;
	localparam int MODE_DIR_BIT = 1;

	// ============================================================
	// Shutdown source select bit positions.
	localparam int SRC_CMP0_BIT = 0;
	localparam int SRC_CMP1_BIT = 1;
	localparam int SRC_INT_BIT = 2;

	// ============================================================
	// Shutdown drive state codes; bit one set means float.
	localparam logic [1:0] SS_DRIVE_LOW = 2'h0;
	localparam logic [1:0] SS_DRIVE_HIGH = 2'h1;
	localparam int SS_FLOAT_BIT = 1;

	// ============================================================
	// Output indices.
	localparam int OUT_A = 0;
	localparam int OUT_B = 1;
	localparam int OUT_C = 2;
	localparam int OUT_D = 3;

	// ============================================================
	// Timing counts and reset values.
	localparam logic [1:0] PHASE_LAST = 2'h3;
	localparam logic [8:0] DIR_LEAD_TIMER_CYCLES = 9'h004;
	localparam int OSC_PER_DEADBAND_UNIT = 4;
	localparam int DB_SHIFT = $clog2(OSC_PER_DEADBAND_UNIT);
	localparam logic [9:0] DUTY_RESET = 10'h000;
	localparam logic [3:0] LEVEL_RESET = 4'h0;
	localparam logic STATUS_RESET = 1'b0;

endpackage

// >>> src/deadband_if.sv
`timescale 1ns/1ps
interface deadband_if;
	logic [1:0] want;
	logic [1:0] act;
	logic [8:0] delay;
	modport ctrl (output want, output delay, input act);
	modport unit (input want, input delay, output act);
endinterface

// >>> src/deadband_delay.sv
`timescale 1ns/1ps
module deadband_delay import pwm_pkg::*; (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// Carrier
	deadband_if.unit db
);

	wire logic [1:0] act_w;

	// ============================================================
	// One delay counter per half-bridge output.
	for (genvar i = 0; i < 2; i++) begin : g_ch
		logic [8:0] cnt_q;
		logic act_q;
		wire logic done;
		assign done = (cnt_q >= db.delay);
		always_ff @(posedge clk_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				cnt_q <= 9'h000;
				act_q <= 1'b0;
			end else if (ce_in) begin
				// Falling edges pass at once, so no delay on turn-off.
				if (!db.want[i]) begin
					cnt_q <= 9'h000;
					act_q <= 1'b0;
				end else if (done) begin
					act_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 9'h001;
				end
			end
		end
		assign act_w[i] = act_q;
	end

	assign db.act = act_w;

endmodule

// >>> src/enhanced_bridge_pwm_output.sv
`timescale 1ns/1ps
module enhanced_bridge_pwm_output import pwm_pkg::*; #(
	parameter bit HAS_CD = 1'b1
) (
	// Clock, reset and clock enable
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// Period timer
	input wire logic [7:0] period_timer_count_in,
	input wire logic [7:0] period_limit_in,
	input wire logic [1:0] phase_bits_in,
	// Modulator control
	input wire logic pwm_enable_in,
	input wire logic [1:0] output_mode_sel_in,
	input wire logic [7:0] duty_high_bits_in,
	input wire logic [1:0] duty_low_bits_in,
	input wire logic [3:0] steer_enable_in,
	input wire logic [6:0] deadband_count_in,
	// Shutdown control
	input wire logic auto_restart_enable_in,
	input wire logic [2:0] shutdown_source_sel_in,
	input wire logic [1:0] shutdown_state_pair_ac_in,
	input wire logic [1:0] shutdown_state_pair_bd_in,
	input wire logic status_write_in,
	input wire logic status_write_value_in,
	// Fault sources
	input wire logic ext_int_in,
	input wire logic [1:0] comparator_fault_out_in,
	// Status
	output logic shutdown_event_status_out,
	output logic period_end_out,
	// Output pins
	output logic out_a_out,
	output logic out_a_oe_n_out,
	output logic out_b_out,
	output logic out_b_oe_n_out,
	output logic out_c_out,
	output logic out_c_oe_n_out,
	output logic out_d_out,
	output logic out_d_oe_n_out
);

	// ============================================================
	// Time base and period boundary.
	wire logic [9:0] time_base;
	wire logic period_end;
	wire logic lead_window;

	assign time_base = {period_timer_count_in, phase_bits_in};
	assign period_end = (period_timer_count_in == period_limit_in) &&
		(phase_bits_in == PHASE_LAST);
	assign lead_window = ({1'b0, period_timer_count_in} +
		DIR_LEAD_TIMER_CYCLES) > {1'b0, period_limit_in};
	assign period_end_out = period_end;

	// ============================================================
	// Mode decode.
	wire logic mode_single;
	wire logic mode_half;
	wire logic mode_full;
	wire logic dir_req;

	assign mode_single = (output_mode_sel_in == MODE_SINGLE);
	assign mode_half = (output_mode_sel_in == MODE_HALF);
	assign mode_full = output_mode_sel_in[MODE_FULL_BIT];
	assign dir_req = output_mode_sel_in[MODE_DIR_BIT];

	// ============================================================
	// Shutdown condition and status.
	wire logic sd_cond;
	wire logic sd_force;
	logic status_q;
	logic status_d;

	assign sd_cond =
		(shutdown_source_sel_in[SRC_CMP0_BIT] & comparator_fault_out_in[0]) |
		(shutdown_source_sel_in[SRC_CMP1_BIT] & comparator_fault_out_in[1]) |
		(shutdown_source_sel_in[SRC_INT_BIT] & ~ext_int_in);

	// The raw condition joins the stored bit so the pins react without
	// waiting for a clock edge.
	assign sd_force = sd_cond | status_q;

	always_comb begin
		status_d = status_q;
		if (sd_cond) begin
			status_d = 1'b1;
		end else if (status_write_in) begin
			status_d = status_write_value_in;
		end else if (auto_restart_enable_in) begin
			status_d = 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			status_q <= STATUS_RESET;
		end else if (ce_in) begin
			status_q <= status_d;
		end
	end

	assign shutdown_event_status_out = status_q;

	// ============================================================
	// Run gate: starts only at a period boundary.
	logic run_q;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			run_q <= 1'b0;
		end else if (ce_in) begin
			if (!pwm_enable_in || sd_force) begin
				run_q <= 1'b0;
			end else if (period_end) begin
				run_q <= 1'b1;
			end
		end
	end

	// ============================================================
	// Duty buffer, loaded for the coming period.
	logic [9:0] duty_q;
	wire logic pwm_raw;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			duty_q <= DUTY_RESET;
		end else if (ce_in && period_end) begin
			duty_q <= {duty_high_bits_in, duty_low_bits_in};
		end
	end

	assign pwm_raw = run_q && (time_base < duty_q);

	// ============================================================
	// Full-bridge direction with early swap.
	logic dir_q;
	logic swap_q;
	wire logic dir_pending;

	assign dir_pending = mode_full && (dir_req != dir_q);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dir_q <= 1'b0;
			swap_q <= 1'b0;
		end else if (ce_in) begin
			if (!mode_full) begin
				dir_q <= dir_req;
				swap_q <= 1'b0;
			end else if (period_end) begin
				dir_q <= dir_req;
				swap_q <= 1'b0;
			end else if (dir_pending && lead_window) begin
				swap_q <= 1'b1;
			end
		end
	end

	// ============================================================
	// Dead-band unit, used only in half-bridge mode.
	deadband_if db_if ();

	assign db_if.want = mode_half ? {~pwm_raw & run_q, pwm_raw} : 2'h0;
	assign db_if.delay = {2'h0, deadband_count_in} << DB_SHIFT;

	deadband_delay u_db (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.db(db_if.unit)
	);

	// ============================================================
	// Output levels and enables per mode.
	logic [3:0] lvl_d;
	logic [3:0] lvl_q;
	logic [3:0] pin_en;
	wire logic [3:0] cd_mask;

	// C and D never drive on half-bridge-only variants.
	assign cd_mask = {HAS_CD, HAS_CD, 2'h3};

	always_comb begin
		lvl_d = 4'h0;
		pin_en = 4'h0;
		if (mode_single) begin
			lvl_d = {4{pwm_raw}} & steer_enable_in;
			pin_en = steer_enable_in;
		end else if (mode_half) begin
			lvl_d[OUT_A] = db_if.act[0];
			lvl_d[OUT_B] = db_if.act[1];
			pin_en = 4'h3;
		end else begin
			pin_en = 4'hf;
			// Direct drive here: no dead band in the full bridge.
			if (!run_q) begin
				lvl_d = 4'h0;
			end else if (swap_q) begin
				lvl_d[OUT_A] = ~dir_req;
				lvl_d[OUT_C] = dir_req;
			end else if (!dir_q) begin
				lvl_d[OUT_A] = 1'b1;
				lvl_d[OUT_D] = pwm_raw;
			end else begin
				lvl_d[OUT_C] = 1'b1;
				lvl_d[OUT_B] = pwm_raw;
			end
		end
		pin_en = pin_en & cd_mask;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lvl_q <= LEVEL_RESET;
		end else if (ce_in) begin
			lvl_q <= lvl_d;
		end
	end

	// ============================================================
	// Pin stage with asynchronous shutdown override.
	wire logic [3:0] pin_val;
	wire logic [3:0] pin_oe_n;

	for (genvar i = 0; i < 4; i++) begin : g_pin
		wire logic [1:0] ss;
		assign ss = (i % 2 == 0) ? shutdown_state_pair_ac_in :
			shutdown_state_pair_bd_in;
		assign pin_val[i] = sd_force ? (ss == SS_DRIVE_HIGH) :
			lvl_q[i];
		assign pin_oe_n[i] = ~pin_en[i] |
			(sd_force & ss[SS_FLOAT_BIT]);
	end

	assign out_a_out = pin_val[OUT_A];
	assign out_b_out = pin_val[OUT_B];
	assign out_c_out = pin_val[OUT_C];
	assign out_d_out = pin_val[OUT_D];
	assign out_a_oe_n_out = pin_oe_n[OUT_A];
	assign out_b_oe_n_out = pin_oe_n[OUT_B];
	assign out_c_oe_n_out = pin_oe_n[OUT_C];
	assign out_d_oe_n_out = pin_oe_n[OUT_D];

endmodule

// >>> verification/switch_drivers.sv
`timescale 1ns/1ps
// ============================================================
// Gate drivers of the two bridge legs
module switch_drivers (
	// Pins from the block
	input wire logic [3:0] pin_in,
	input wire logic [3:0] oe_n_in,
	// Gate levels seen by the switches
	output logic [3:0] gate_out,
	output logic shoot_out
);
	// Each gate has a pull-down, so a released pin turns its switch off.
	assign gate_out = pin_in & ~oe_n_in;
	assign shoot_out = (gate_out[0] & gate_out[1]) |
		(gate_out[2] & gate_out[3]);
endmodule

// >>> verification/enhanced_bridge_pwm_output_chk.sv
`timescale 1ns/1ps
// ============================================================
// Port checker
module enhanced_bridge_pwm_output_chk import pwm_pkg::*; (
	// Clock and controls
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic [7:0] period_timer_count_in,
	input wire logic [7:0] period_limit_in,
	input wire logic [1:0] phase_bits_in,
	input wire logic [1:0] output_mode_sel_in,
	input wire logic [3:0] steer_enable_in,
	input wire logic auto_restart_enable_in,
	input wire logic [2:0] shutdown_source_sel_in,
	input wire logic [1:0] shutdown_state_pair_ac_in,
	input wire logic [1:0] shutdown_state_pair_bd_in,
	input wire logic status_write_in,
	input wire logic ext_int_in,
	input wire logic [1:0] comparator_fault_out_in,
	// Design outputs
	input wire logic shutdown_event_status_out,
	input wire logic period_end_out,
	input wire logic out_a_out,
	input wire logic out_a_oe_n_out,
	input wire logic out_b_out,
	input wire logic out_b_oe_n_out,
	input wire logic out_c_oe_n_out,
	input wire logic out_d_out,
	input wire logic out_d_oe_n_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	logic fault;
	logic sd;
	logic [1:0] mode;
	// Faults are unclocked, so pins must follow them in the same cycle.
	assign fault = (shutdown_source_sel_in[SRC_CMP0_BIT] &
		comparator_fault_out_in[0]) | (shutdown_source_sel_in[SRC_CMP1_BIT] &
		comparator_fault_out_in[1]) | (shutdown_source_sel_in[SRC_INT_BIT] &
		!ext_int_in);
	assign sd = fault | shutdown_event_status_out;
	assign mode = output_mode_sel_in;
	// ============================================================
	// Assertions
	chk_period_end_flag: assert property (period_end_out == (
		phase_bits_in == PHASE_LAST &&
		period_timer_count_in == period_limit_in)) else $error("period end");
	chk_single_steer_oe: assert property (
		mode == MODE_SINGLE && !sd |->
		out_a_oe_n_out == !steer_enable_in[OUT_A] &&
		out_d_oe_n_out == !steer_enable_in[OUT_D]) else $error("steering");
	chk_half_no_cd: assert property (mode == MODE_HALF |->
		out_c_oe_n_out && out_d_oe_n_out) else $error("half drives c or d");
	chk_full_bd_apart: assert property (
		mode[0] && $past(mode[0]) && !sd |->
		!(out_b_out && out_d_out)) else $error("b and d both active");
	chk_sd_low_ac: assert property (fault && !out_a_oe_n_out &&
		shutdown_state_pair_ac_in == SS_DRIVE_LOW |-> !out_a_out)
		else $error("a not forced low");
	chk_sd_high_bd: assert property (fault && !out_b_oe_n_out &&
		shutdown_state_pair_bd_in == SS_DRIVE_HIGH |-> out_b_out)
		else $error("b not forced high");
	chk_sd_float_ac: assert property (fault &&
		shutdown_state_pair_ac_in[SS_FLOAT_BIT] |-> out_a_oe_n_out)
		else $error("a not released");
	chk_sd_status_set: assert property (fault && ce_in |=>
		shutdown_event_status_out) else $error("status not set");
	chk_status_held: assert property (shutdown_event_status_out &&
		!auto_restart_enable_in && !status_write_in |=>
		shutdown_event_status_out) else $error("status dropped");
	chk_auto_clear: assert property (
		shutdown_event_status_out && !fault &&
		auto_restart_enable_in && !status_write_in && ce_in |-> ##1
		!shutdown_event_status_out) else $error("status not cleared");
	cover property (fault ##1 shutdown_event_status_out);
	cover property ($fell(shutdown_event_status_out));
	cover property (mode == MODE_HALF && out_a_out && !out_a_oe_n_out);
endmodule

// >>> verification/enhanced_bridge_pwm_output_bench.sv
`timescale 1ns/1ps
// ============================================================
// Stimulus and wiring
module enhanced_bridge_pwm_output_bench import pwm_pkg::*;;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic ce_in = 1'b1;
	logic [7:0] period_timer_count_in = 8'h00;
	logic [7:0] period_limit_in = 8'h0f;
	logic [1:0] phase_bits_in = 2'h0;
	logic pwm_enable_in = 1'b0;
	logic [1:0] output_mode_sel_in = 2'h0;
	logic [9:0] duty = 10'h000;
	logic [7:0] duty_high_bits_in;
	logic [1:0] duty_low_bits_in;
	logic [3:0] steer_enable_in = 4'h0;
	logic [6:0] deadband_count_in = 7'h00;
	logic auto_restart_enable_in = 1'b0;
	logic [2:0] shutdown_source_sel_in = 3'h0;
	logic [1:0] shutdown_state_pair_ac_in = 2'h0;
	logic [1:0] shutdown_state_pair_bd_in = 2'h0;
	logic status_write_in = 1'b0;
	logic status_write_value_in = 1'b0;
	logic ext_int_in = 1'b1;
	logic [1:0] comparator_fault_out_in = 2'h0;
	logic shutdown_event_status_out, period_end_out;
	logic out_a_out, out_a_oe_n_out, out_b_out, out_b_oe_n_out;
	logic out_c_out, out_c_oe_n_out, out_d_out, out_d_oe_n_out;
	logic [3:0] gate;
	logic shoot;
	int fails = 0;
	int check_count = 0;
	assign {duty_high_bits_in, duty_low_bits_in} = duty;
	enhanced_bridge_pwm_output i_dut (.*);
	switch_drivers i_far (
		.pin_in({out_d_out, out_c_out, out_b_out, out_a_out}),
		.oe_n_in({out_d_oe_n_out, out_c_oe_n_out, out_b_oe_n_out,
			out_a_oe_n_out}),
		.gate_out(gate),
		.shoot_out(shoot)
	);
	initial begin
		forever #5 clk_in = ~clk_in;
	end
	// The period timer lives outside the block, so the bench runs it.
	always @(posedge clk_in) begin
		#1;
		phase_bits_in = phase_bits_in + 2'h1;
		if (phase_bits_in == 2'h0) begin
			period_timer_count_in = (period_timer_count_in == period_limit_in) ?
				8'h00 : period_timer_count_in + 8'h01;
		end
	end
	// ============================================================
	// Shared tasks
	task automatic results();
		if (fails == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic wait_pe();
		int i;
		i = 0;
		@(negedge clk_in);
		while (period_end_out !== 1'b1) begin
			i++;
			if (i > 300) begin
				fails++;
				results();
			end
			@(negedge clk_in);
		end
	endtask
	// Counts over one whole period, so pipeline delay does not matter.
	task automatic meas(input logic [6:0] ea, eb, ec, ed);
		logic [6:0] n [4];
		logic [6:0] sh;
		n = '{default: 7'h00};
		sh = 7'h00;
		wait_pe();
		step(1);
		wait_pe();
		repeat (64) begin
			for (int k = 0; k < 4; k++) n[k] = n[k] + 7'(gate[k]);
			sh = sh + 7'(shoot);
			@(negedge clk_in);
		end
		check({n[0], n[1], n[2], n[3], sh}, {ea, eb, ec, ed, 7'h00});
		step(1);
	endtask
	// ============================================================
	// Scenarios
	task automatic s_single();
		steer_enable_in = 4'h5;
		duty = 10'h015;
		wait_pe();
		step(1);
		pwm_enable_in = 1'b1;
		step(3);
		check(gate, 4'h0);
		meas(7'h15, 7'h00, 7'h15, 7'h00);
		check({out_b_oe_n_out, out_d_oe_n_out}, 2'h3);
	endtask
	task automatic s_half();
		output_mode_sel_in = MODE_HALF;
		duty = 10'h028;
		deadband_count_in = 7'h02;
		meas(7'h20, 7'h10, 7'h00, 7'h00);
		deadband_count_in = 7'h0c;
		meas(7'h00, 7'h00, 7'h00, 7'h00);
	endtask
	task automatic s_full();
		output_mode_sel_in = MODE_FULL_FWD;
		duty = 10'h014;
		meas(7'h40, 7'h00, 7'h00, 7'h14);
		wait_pe();
		step(1);
		output_mode_sel_in = MODE_FULL_REV;
		step(5);
		check(gate, 4'h9);
		wait_pe();
		check(gate, 4'h4);
		meas(7'h00, 7'h14, 7'h40, 7'h00);
	endtask
	task automatic s_shut();
		output_mode_sel_in = MODE_HALF;
		duty = 10'h028;
		deadband_count_in = 7'h02;
		shutdown_source_sel_in = 3'h4;
		for (int i = 0; i < 3; i++) begin
			shutdown_state_pair_ac_in = i[1:0];
			shutdown_state_pair_bd_in = i[1:0];
			ext_int_in = 1'b0;
			step(1);
			check({gate[1:0], out_a_oe_n_out, out_b_oe_n_out,
				shutdown_event_status_out}, {{2{i == 1}}, {2{i == 2}}, 1'b1});
		end
		status_write_in = 1'b1;
		step(1);
		status_write_in = 1'b0;
		ext_int_in = 1'b1;
		step(3);
		check(shutdown_event_status_out, 1'b1);
		status_write_in = 1'b1;
		step(1);
		status_write_in = 1'b0;
		step(1);
		check({gate[1:0], shutdown_event_status_out}, 3'h0);
		auto_restart_enable_in = 1'b1;
		shutdown_source_sel_in = 3'h3;
		for (int j = 1; j < 3; j++) begin
			comparator_fault_out_in = j[1:0];
			step(2);
			check(shutdown_event_status_out, 1'b1);
			comparator_fault_out_in = 2'h0;
			step(2);
			check(shutdown_event_status_out, 1'b0);
		end
		// A low clock enable must hold the status through a cleared fault.
		comparator_fault_out_in = 2'h1;
		step(1);
		ce_in = 1'b0;
		comparator_fault_out_in = 2'h0;
		step(2);
		check(shutdown_event_status_out, 1'b1);
		ce_in = 1'b1;
		step(1);
		check(shutdown_event_status_out, 1'b0);
		meas(7'h20, 7'h10, 7'h00, 7'h00);
	endtask
	initial begin
		repeat (4) @(posedge clk_in);
		#1;
		rst_n_in = 1'b1;
		check(shutdown_event_status_out, 1'b0);
		s_single();
		s_half();
		s_full();
		s_shut();
		results();
	end
endmodule

bind enhanced_bridge_pwm_output enhanced_bridge_pwm_output_chk i_chk (.*);
